// >>> verilog/host_port_mode_and_serial_pins.sv
// Host configuration port: mode strap, serial shift port and two-wire port
// What this block does
// - Strap sets select bit during reset
// - After reset, select bit alone picks mode
// - Strap level always mirrored in pin state
// - Edge select picks serial output edge
// - Serial input sampled on shift clock rise
// - Read data shifted out on chosen edge
// - Two-wire target answers pin-set address only
// - Two-wire mode reuses serial pins
`timescale 1ns/10ps
`default_nettype none
module host_port_mode_and_serial_pins (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_bus_id_bit0_in,
    input wire logic bus_id_bit1_in,
    input wire logic bus_id_bit2_in,
    input wire logic host_port_strap_pin_in,
    input wire logic output_edge_select_in,
    input wire logic serial_in_pin_in,
    input wire logic serial_out_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out,
    output logic host_port_mode_out,
    output logic mode_ready_out
);
    // Synchronised pin levels in the system clock domain
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    logic strap_s; // Mode strap pin
    logic cs_n_s; // Chip select, also id bit 0
    logic id1_s;
    logic id2_s;
    logic scl_s; // Shift clock seen as a level
    logic sda_s; // Data line seen as a level

    // Register file and mode control, system domain
    logic [7:0] sel_r, sel_nxt; // Select configuration register
    logic [7:0] pin_state_r, pin_state_nxt; // Pin state register
    logic [7:0] settle_r, settle_nxt; // Mode settle counter
    logic ready_nxt;
    logic [15:0] snap_r, snap_nxt; // Frozen {pin state, select} for reads
    logic full_d_r, full_d_nxt; // Previous synced frame-full level
    logic full_s; // Frame-full level after two flops
    logic ser_oe_r, ser_oe_nxt; // Serial output driving
    logic ser_wr; // Completed serial write to select reg
    logic serial_mode; // Active mode is the serial port
    logic i2c_oe; // Two-wire engine pulls data low

    // Serial engine, shift clock domain
    logic [4:0] cnt_r, cnt_nxt; // Rising edges seen in this frame
    logic [15:0] sh_r, sh_nxt; // Frame shift register
    logic [7:0] rd_r, rd_nxt; // Read data of the frame
    logic pos_bit_r, pos_bit_nxt; // Output bit for rising-edge update
    logic neg_bit_r, neg_bit_nxt; // Output bit for falling-edge update
    logic edge_meta_r, edge_sel_r; // Edge select synchroniser
    logic [15:0] word_in;
    logic [7:0] rd_val;
    logic [1:0] full_sync_r; // Frame-full crossing into system domain

    host_port_reg_if tw_bus ();

    // Pin inputs pass two flops before system-domain logic
    assign pin_raw = {host_port_strap_pin_in, cs_n_bus_id_bit0_in,
                      bus_id_bit1_in, bus_id_bit2_in, sclk_in, serial_out_pin_in};

    host_port_sync #(
        .WIDTH(6)
    ) pin_sync (
        .clk_in(clk_in),
        .d_in(pin_raw),
        .q_out(pin_s)
    );

    assign strap_s = pin_s[5];
    assign cs_n_s = pin_s[4];
    assign id1_s = pin_s[3];
    assign id2_s = pin_s[2];
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // Mode comes from the register bit, never the pin
    assign serial_mode = (sel_r[host_port_pkg::SEL_MODE_BIT] == host_port_pkg::MODE_SERIAL);
    assign host_port_mode_out = sel_r[host_port_pkg::SEL_MODE_BIT];

    // Two-wire target on the shift clock and data pins
    host_port_i2c_target tw_target (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(~serial_mode & mode_ready_out),
        .dev_addr_in({host_port_pkg::I2C_BASE_ADDR, id2_s, id1_s, cs_n_s}),
        .scl_in(scl_s),
        .sda_in(sda_s),
        .sda_oe_out(i2c_oe),
        .reg_bus(tw_bus.engine)
    );

    // Read data for the two-wire engine
    assign tw_bus.rdata = host_port_pkg::reg_read(tw_bus.addr, pin_state_r, sel_r);

    // Frame-full flag of the shift domain, taken over by two flops.
    // The frame word is stable once full, so it is read directly.
    always_ff @(posedge clk_in) begin
        full_sync_r <= {full_sync_r[0], cnt_r[4]};
    end
    assign full_s = full_sync_r[1];

    // A serial write lands once per frame, on the full-flag rise
    assign ser_wr = serial_mode && mode_ready_out && full_s && !full_d_r &&
                    !sh_r[15] && (sh_r[14:8] == host_port_pkg::SELECT_CFG_ADDR);

    // System-domain next values
    always_comb begin
        sel_nxt = sel_r;
        settle_nxt = settle_r;
        ready_nxt = mode_ready_out;
        snap_nxt = snap_r;
        full_d_nxt = full_s;
        // Strap level mirrored whether in reset or not
        pin_state_nxt = {host_port_pkg::PIN_UPPER_ZERO, strap_s};
        ser_oe_nxt = serial_mode && mode_ready_out && !cs_n_s;
        if (sys_rst_in) begin
            // Select default follows the strap while reset is held
            sel_nxt = {host_port_pkg::SEL_UPPER_RESET, strap_s};
            settle_nxt = 8'h00;
            ready_nxt = 1'b0;
            full_d_nxt = 1'b0;
            ser_oe_nxt = 1'b0;
        end else begin
            // Hold the ports off until the mode has settled
            if (settle_r != host_port_pkg::SETTLE_LAST) begin
                settle_nxt = settle_r + 8'h01;
            end else begin
                ready_nxt = 1'b1;
            end
            // Register writes from whichever engine owns the port
            if (ser_wr) begin
                sel_nxt = sh_r[7:0];
            end else if (tw_bus.wr_stb && tw_bus.addr == host_port_pkg::SELECT_CFG_ADDR) begin
                sel_nxt = tw_bus.wdata;
            end
        end
        // Read image refreshes only between frames, so it stands still
        // while the shift domain samples it
        if (cs_n_s) begin
            snap_nxt = {pin_state_r, sel_r};
        end
    end

    // System-domain registers
    always_ff @(posedge clk_in) begin
        sel_r <= sel_nxt;
        pin_state_r <= pin_state_nxt;
        settle_r <= settle_nxt;
        mode_ready_out <= ready_nxt;
        snap_r <= snap_nxt;
        full_d_r <= full_d_nxt;
        ser_oe_r <= ser_oe_nxt;
    end

    // Shared data pin: push-pull in serial mode, open drain otherwise
    always_comb begin
        if (serial_mode) begin
            // Edge select decides which copy reaches the pin
            serial_out_pin_out = edge_sel_r ? neg_bit_r : pos_bit_r;
            serial_out_pin_oe_out = ser_oe_r;
        end else begin
            serial_out_pin_out = 1'b0;
            serial_out_pin_oe_out = i2c_oe;
        end
    end

    // Serial frame bits, MSB first: R/W, address, data
    assign word_in = {sh_r[14:0], serial_in_pin_in};
    assign rd_val = host_port_pkg::reg_read(word_in[6:0], snap_r[15:8], snap_r[7:0]);

    // Shift-domain next values on the rising edge
    always_comb begin
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        pos_bit_nxt = pos_bit_r;
        if (cnt_r < host_port_pkg::FRAME_BITS) begin
            // Every rising edge takes one input bit
            sh_nxt = word_in;
            cnt_nxt = cnt_r + 5'h01;
        end
        if (cnt_r == host_port_pkg::FRAME_ADDR_LAST) begin
            // Address complete: fetch data, first bit on rising mode
            rd_nxt = rd_val;
            pos_bit_nxt = rd_val[7];
        end else if (cnt_r > host_port_pkg::FRAME_ADDR_LAST &&
                     cnt_r <= host_port_pkg::FRAME_BIT_LAST) begin
            pos_bit_nxt = rd_r[3'(host_port_pkg::FRAME_BIT_LAST - cnt_r)];
        end
    end

    // Shift-domain registers; chip select high ends the frame
    always_ff @(posedge sclk_in or posedge cs_n_bus_id_bit0_in) begin
        if (cs_n_bus_id_bit0_in) begin
            cnt_r <= 5'h00;
            sh_r <= 16'h0000;
            rd_r <= 8'h00;
            pos_bit_r <= 1'b0;
            edge_meta_r <= 1'b0;
            edge_sel_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            pos_bit_r <= pos_bit_nxt;
            edge_meta_r <= output_edge_select_in;
            edge_sel_r <= edge_meta_r;
        end
    end

    // Falling-edge copy: next data bit after each rise in the data phase
    always_comb begin
        neg_bit_nxt = neg_bit_r;
        if (cnt_r > host_port_pkg::FRAME_ADDR_LAST && cnt_r < host_port_pkg::FRAME_BITS) begin
            neg_bit_nxt = rd_r[3'(host_port_pkg::FRAME_BIT_LAST + 5'h01 - cnt_r)];
        end
    end

    // Falling-edge register, cleared with the frame
    always_ff @(negedge sclk_in or posedge cs_n_bus_id_bit0_in) begin
        if (cs_n_bus_id_bit0_in) begin
            neg_bit_r <= 1'b0;
        end else begin
            neg_bit_r <= neg_bit_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/host_port_pkg.sv
// Shared constants, types and helpers for the host configuration port
package host_port_pkg;

    // Clock and mode settle timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MODE_SETTLE_NS = 10000;
    localparam int MODE_SETTLE_CYC = (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_LAST = 8'(MODE_SETTLE_CYC - 1);

    // Register offsets (7-bit register address space)
    localparam logic [6:0] PIN_STATE_ADDR = 7'h02;
    localparam logic [6:0] SELECT_CFG_ADDR = 7'h7F;

    // Field positions and reset values
    localparam int SEL_MODE_BIT = 0;
    localparam int STRAP_BIT = 0;
    localparam logic [6:0] SEL_UPPER_RESET = 7'h00;
    localparam logic [6:0] PIN_UPPER_ZERO = 7'h00;

    // Interface select encodings of the mode bit
    localparam logic MODE_I2C = 1'b0;
    localparam logic MODE_SERIAL = 1'b1;

    // Serial frame: R/W, 7 address bits, 8 data bits
    localparam logic [4:0] FRAME_ADDR_LAST = 5'h07;
    localparam logic [4:0] FRAME_BIT_LAST = 5'h0E;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // Upper four bits of the two-wire target address, value arbitrary
    localparam logic [3:0] I2C_BASE_ADDR = 4'hA;
    localparam logic [3:0] I2C_ACK_CNT = 4'h8;

    // Two-wire target states
    typedef enum logic [2:0] {
        TW_IDLE,
        TW_ADDR,
        TW_REG,
        TW_WDATA,
        TW_RDATA,
        TW_MACK
    } tw_state_t;

    // Register read decode, used by both host engines
    function automatic logic [7:0] reg_read(input logic [6:0] addr,
                                            input logic [7:0] pin_state,
                                            input logic [7:0] sel_cfg);
        logic [7:0] val;
        val = 8'h00;
        if (addr == PIN_STATE_ADDR) begin
            val = pin_state;
        end else if (addr == SELECT_CFG_ADDR) begin
            val = sel_cfg;
        end
        return val;
    endfunction

endpackage

// >>> verilog/host_port_reg_if.sv
// Register access carrier between the two-wire engine and the register file
`timescale 1ns/10ps
`default_nettype none
interface host_port_reg_if;
    logic wr_stb; // One-cycle write strobe
    logic [6:0] addr; // Register pointer
    logic [7:0] wdata; // Write data
    logic [7:0] rdata; // Read data at addr

    // Engine side issues accesses
    modport engine (output wr_stb, output addr, output wdata, input rdata);
    // Register side answers them
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> verilog/host_port_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
`default_nettype none
module host_port_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by the second
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    // No reset: the strap must be seen while reset is held
    always_comb begin
        meta_nxt = d_in;
        q_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge clk_in) begin
        meta_r <= meta_nxt;
        q_out <= q_nxt;
    end
endmodule
`default_nettype wire

// >>> verilog/host_port_i2c_target.sv
// Two-wire bus target, oversampled on the system clock
`timescale 1ns/10ps
`default_nettype none
module host_port_i2c_target (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic [6:0] dev_addr_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    host_port_reg_if.engine reg_bus
);
    host_port_pkg::tw_state_t state_r, state_nxt; // Protocol state
    logic [3:0] cnt_r, cnt_nxt; // Bit counter
    logic [7:0] sh_r, sh_nxt; // Shift register
    logic [6:0] ptr_r, ptr_nxt; // Register pointer
    logic ack_r, ack_nxt; // Driving an acknowledge slot
    logic nack_r, nack_nxt; // Master refused more read data
    logic oe_nxt;
    logic wr_nxt;
    logic scl_d_r, sda_d_r; // Previous line levels for edges
    logic rise, fall, start, stop;

    // Line events from the already synchronised levels
    assign rise = scl_in & ~scl_d_r;
    assign fall = ~scl_in & scl_d_r;
    assign start = scl_in & scl_d_r & sda_d_r & ~sda_in;
    assign stop = scl_in & scl_d_r & ~sda_d_r & sda_in;

    assign reg_bus.addr = ptr_r;
    assign reg_bus.wdata = sh_r;

    // Next-state logic of the target
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        ack_nxt = ack_r;
        nack_nxt = nack_r;
        oe_nxt = sda_oe_out;
        wr_nxt = 1'b0;
        if (!enable_in || stop) begin
            // Bus released, or port owned by the serial mode
            state_nxt = host_port_pkg::TW_IDLE;
            oe_nxt = 1'b0;
            ack_nxt = 1'b0;
        end else if (start) begin
            // Start or repeated start restarts addressing
            state_nxt = host_port_pkg::TW_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
            ack_nxt = 1'b0;
        end else begin
            unique case (state_r)
                host_port_pkg::TW_IDLE: begin
                    oe_nxt = 1'b0;
                end
                host_port_pkg::TW_ADDR, host_port_pkg::TW_REG,
                host_port_pkg::TW_WDATA: begin
                    if (rise && cnt_r < host_port_pkg::I2C_ACK_CNT) begin
                        // Sample data while the clock is high
                        sh_nxt = {sh_r[6:0], sda_in};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (fall && cnt_r == host_port_pkg::I2C_ACK_CNT && !ack_r) begin
                        ack_nxt = 1'b1;
                        if (state_r == host_port_pkg::TW_ADDR) begin
                            // Answer only our own pin-set address
                            oe_nxt = (sh_r[7:1] == dev_addr_in);
                            if (sh_r[7:1] != dev_addr_in) begin
                                state_nxt = host_port_pkg::TW_IDLE;
                            end
                        end else begin
                            oe_nxt = 1'b1;
                            if (state_r == host_port_pkg::TW_REG) begin
                                ptr_nxt = sh_r[6:0];
                            end else begin
                                wr_nxt = 1'b1;
                            end
                        end
                    end else if (fall && ack_r) begin
                        // Acknowledge slot over, pick next phase
                        ack_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        oe_nxt = 1'b0;
                        if (state_r == host_port_pkg::TW_ADDR && sh_r[0]) begin
                            state_nxt = host_port_pkg::TW_RDATA;
                            sh_nxt = reg_bus.rdata;
                            oe_nxt = ~reg_bus.rdata[7];
                        end else if (state_r == host_port_pkg::TW_ADDR) begin
                            state_nxt = host_port_pkg::TW_REG;
                        end else begin
                            state_nxt = host_port_pkg::TW_WDATA;
                        end
                    end
                end
                host_port_pkg::TW_RDATA: begin
                    if (fall) begin
                        // Data moves only while the clock is low
                        sh_nxt = {sh_r[6:0], 1'b0};
                        cnt_nxt = cnt_r + 4'h1;
                        oe_nxt = (cnt_r < 4'h7) ? ~sh_r[6] : 1'b0;
                        if (cnt_r == 4'h7) begin
                            state_nxt = host_port_pkg::TW_MACK;
                        end
                    end
                end
                host_port_pkg::TW_MACK: begin
                    if (rise) begin
                        nack_nxt = sda_in;
                    end else if (fall) begin
                        cnt_nxt = 4'h0;
                        if (nack_r) begin
                            state_nxt = host_port_pkg::TW_IDLE;
                            oe_nxt = 1'b0;
                        end else begin
                            state_nxt = host_port_pkg::TW_RDATA;
                            sh_nxt = reg_bus.rdata;
                            oe_nxt = ~reg_bus.rdata[7];
                        end
                    end
                end
            endcase
        end
    end

    // Register the target state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= host_port_pkg::TW_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 7'h00;
            ack_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_out <= 1'b0;
            reg_bus.wr_stb <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            ack_r <= ack_nxt;
            nack_r <= nack_nxt;
            sda_oe_out <= oe_nxt;
            reg_bus.wr_stb <= wr_nxt;
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
        end
    end
endmodule
`default_nettype wire

// >>> tb/host_port_props.sv
// Concurrent checks on the host port top-level pins
`timescale 1ns/10ps
`default_nettype none
module host_port_props (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_bus_id_bit0_in,
    input wire logic host_port_strap_pin_in,
    input wire logic serial_out_pin_out,
    input wire logic serial_out_pin_oe_out,
    input wire logic host_port_mode_out,
    input wire logic mode_ready_out
);
    // Cycles since reset release, saturating so long runs cannot wrap
    logic [9:0] rel_cnt_r;
    logic [9:0] rel_cnt_nxt;
    // Next count
    always_comb begin
        rel_cnt_nxt = rel_cnt_r;
        if (sys_rst_in) begin
            rel_cnt_nxt = 10'h000;
        end else if (rel_cnt_r != 10'h3FF) begin
            rel_cnt_nxt = rel_cnt_r + 10'h001;
        end
    end
    // Count register
    always_ff @(posedge clk_in) begin
        rel_cnt_r <= rel_cnt_nxt;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Reset-time checks override the default disable, they must run in reset
    property p_strap_hi; disable iff (1'b0)
        (sys_rst_in && host_port_strap_pin_in)[*5] |=> host_port_mode_out; endproperty
    a_strap_hi: assert property (p_strap_hi) else $error("mode ignores strap");
    property p_ready_rst; disable iff (1'b0) sys_rst_in |=> !mode_ready_out; endproperty
    a_ready_rst: assert property (p_ready_rst) else $error("ready in reset");
    // Ready neither early nor late against the settle count
    property p_ready_early; rel_cnt_r < 10'h0FA |-> !mode_ready_out; endproperty
    a_ready_early: assert property (p_ready_early) else $error("ready early");
    property p_ready_late; rel_cnt_r > 10'h0FB |-> mode_ready_out; endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready late");
    property p_oe_ready; !mode_ready_out && !$past(mode_ready_out) |-> !serial_out_pin_oe_out;
    endproperty
    a_oe_ready: assert property (p_oe_ready) else $error("drive before ready");
    // Serial drive follows chip select
    property p_oe_idle; (cs_n_bus_id_bit0_in && host_port_mode_out)[*5] |-> !serial_out_pin_oe_out;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("drive while deselected");
    property p_oe_sel;
        (!cs_n_bus_id_bit0_in && host_port_mode_out && mode_ready_out)[*5] |-> serial_out_pin_oe_out;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("no drive while selected");
    // Mode held without a write, whatever the strap does
    property p_mode_keep; (cs_n_bus_id_bit0_in && host_port_mode_out)[*8] |=> host_port_mode_out;
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode lost");
    // Two-wire: data pin only pulled low, acknowledge starts with clock low
    property p_tw_out; !host_port_mode_out |-> !serial_out_pin_out; endproperty
    a_tw_out: assert property (p_tw_out) else $error("two-wire drives high");
    property p_tw_ack; !host_port_mode_out && $rose(serial_out_pin_oe_out) |-> !sclk_in;
    endproperty
    a_tw_ack: assert property (p_tw_ack) else $error("ack at clock high");
    c_ser: cover property (host_port_mode_out && $rose(serial_out_pin_oe_out));
    c_ack: cover property (!host_port_mode_out && $rose(serial_out_pin_oe_out));
    c_sw: cover property ($fell(host_port_mode_out));
endmodule
`default_nettype wire

// >>> tb/host_master.sv
// Behavioural host microprocessor: serial frames and two-wire address probes
`timescale 1ns/10ps
`default_nettype none
module host_master (
    input wire logic sda_w_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    output logic sda_m_out
);
    // Idle: deselected, shift clock still, data pins at pull levels
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b0;
        sdi_out = 1'b0;
        sda_m_out = 1'b1;
        #5;
        // A real rising select clears the frame logic, which has no other reset
        cs_n_out = 1'b1;
    end
    // One frame at 12 ns; ra taken before the eight data-bit rises, rb before the falls of bits 7 to 14
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] ra, output logic [7:0] rb);
        logic [15:0] f;
        f = {rw, a, d};
        ra = 8'h00;
        rb = 8'h00;
        cs_n_out = 1'b0;
        #170;
        for (int i = 0; i < 16; i++) begin
            sdi_out = f[15 - i];
            #6;
            if (i > 7) begin
                ra[15 - i] = sda_w_in;
            end
            sclk_out = 1'b1;
            #5;
            if (i > 6 && i < 15) begin
                rb[14 - i] = sda_w_in;
            end
            #1;
            sclk_out = 1'b0;
        end
        // Held low past the write settle; long idle lets the read image refresh
        #200;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
        #200;
    endtask
    // Start, nb bytes each with a ninth clock for acknowledge, stop; first ack kept; slow bus
    task automatic probe(input logic [23:0] b, input int nb, output logic ack);
        sclk_out = 1'b1;
        #200;
        sda_m_out = 1'b0;
        #200;
        for (int i = 0; i < 9 * nb; i++) begin
            sclk_out = 1'b0;
            #100;
            sda_m_out = (i % 9 < 8) ? b[23 - i + i / 9] : 1'b1;
            #100;
            sclk_out = 1'b1;
            #100;
            if (i == 8) begin
                ack = ~sda_w_in;
            end
            #100;
        end
        sclk_out = 1'b0;
        #100;
        sda_m_out = 1'b0;
        #100;
        sclk_out = 1'b1;
        #200;
        sda_m_out = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// >>> tb/host_port_mode_and_serial_pins_tb.sv
// Self-checking bench for the host port strap, serial and two-wire pins
`timescale 1ns/10ps
`default_nettype none
module host_port_mode_and_serial_pins_tb;
    logic clk, rst, strap, edge_sel, id1, id2; // Bench-driven pins
    logic sclk, cs_n, serial_in_pin, sda_m, sda_w; // Host-side link pins
    logic so, oe, mode, ready, ack; // Design outputs and probe acknowledge
    logic [7:0] ra, rb; // Read samples
    int bad_count, num_checks, n;
    // Shared data wire: pull-up unless someone pulls low
    assign sda_w = (oe ? so : 1'b1) & sda_m;
    always #20 clk = ~clk;
    host_port_mode_and_serial_pins i_host_port_mode_and_serial_pins (
        .clk_in(clk), .sys_rst_in(rst), .sclk_in(sclk), .cs_n_bus_id_bit0_in(cs_n),
        .bus_id_bit1_in(id1), .bus_id_bit2_in(id2), .host_port_strap_pin_in(strap),
        .output_edge_select_in(edge_sel), .serial_in_pin_in(serial_in_pin), .serial_out_pin_in(sda_w),
        .serial_out_pin_out(so), .serial_out_pin_oe_out(oe), .host_port_mode_out(mode),
        .mode_ready_out(ready));
    host_master i_host_master (.sda_w_in(sda_w), .sclk_out(sclk), .cs_n_out(cs_n),
        .sdi_out(serial_in_pin), .sda_m_out(sda_m));
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Serial read; rb shows whether data moved at the rise or the fall
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        i_host_master.xfer(1'b1, a, 8'h00, ra, rb);
        chk("rd_data", exp, ra);
        chk("rd_edge", edge_sel ? {1'b0, exp[7:1]} : exp, edge_sel ? {1'b0, rb[6:0]} : rb);
    endtask
    // Reset with a given strap level, 6 cycles
    task automatic do_reset(input logic s);
        strap = s;
        rst = 1'b1;
        repeat (6) @(negedge clk);
        chk("mode_in_reset", {7'h00, s}, {7'h00, mode});
        chk("ready_in_reset", 8'h00, {7'h00, ready});
        rst = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        strap = 1'b0;
        edge_sel = 1'b0;
        id1 = 1'b0; // Grounded in serial mode
        id2 = 1'b0;
        bad_count = 0;
        num_checks = 0;
        do_reset(1'b0);
        @(negedge clk); // One released edge before the second reset
        do_reset(1'b1);
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n == 400) begin
            bad_count++;
            tally_and_finish();
        end
        chk("ready_cycles", 8'hFA, n[7:0]);
        strap = 1'b0;
        repeat (8) @(negedge clk);
        chk("mode_after_strap", 8'h01, {7'h00, mode});
        // Both output edges, strap mirrored, read-write and read-only places
        for (int e = 0; e < 2; e++) begin
            @(negedge clk);
            edge_sel = e[0];
            strap = e[0];
            repeat (4) @(negedge clk); // Strap must reach the read image first
            rd(7'h02, {7'h00, e[0]});
            i_host_master.xfer(1'b0, 7'h7F, e[0] ? 8'h81 : 8'h4B, ra, rb);
            rd(7'h7F, e[0] ? 8'h81 : 8'h4B);
            i_host_master.xfer(1'b0, 7'h02, 8'hFE, ra, rb);
            rd(7'h02, {7'h00, e[0]});
            rd(7'h33, 8'h00);
        end
        i_host_master.xfer(1'b0, 7'h7F, 8'h00, ra, rb);
        chk("mode_by_register", 8'h00, {7'h00, mode});
        rd(7'h7F, 8'hFF);
        @(negedge clk);
        id2 = 1'b1;
        i_host_master.probe({8'hAC, 16'h0000}, 1, ack);
        chk("ack_other", 8'h00, {7'h00, ack});
        i_host_master.probe({8'hAA, 8'h7F, 8'h01}, 3, ack);
        chk("ack_match", 8'h01, {7'h00, ack});
        chk("mode_by_two_wire", 8'h01, {7'h00, mode});
        tally_and_finish();
    end
endmodule
bind host_port_mode_and_serial_pins host_port_props i_host_port_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk_in),
    .cs_n_bus_id_bit0_in(cs_n_bus_id_bit0_in), .host_port_strap_pin_in(host_port_strap_pin_in),
    .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_out(serial_out_pin_oe_out),
    .host_port_mode_out(host_port_mode_out), .mode_ready_out(mode_ready_out));
`default_nettype wire
